// ### hw/pll_regs_defines.svh
`ifndef PLL_REGS_DEFINES_SVH
`define PLL_REGS_DEFINES_SVH

// register word indices; the bus byte address is four times the index
`define IDX_CAL_CTRL 12'h018
`define IDX_CNT_DLY 12'h019
`define IDX_MON_LOCK 12'h01a
`define IDX_HOLDOVER 12'h01d
`define IDX_UPDATE 12'h232
`define IDX_STATUS 12'h233

// field positions
`define CAL_NOW_BIT 0
`define SYNC_MODE_HI 7
`define SYNC_MODE_LO 6
`define RDLY_HI 5
`define RDLY_LO 3
`define NDLY_HI 2
`define NDLY_LO 0
`define THR_BIT 6
`define LDSEL_HI 5
`define LDSEL_LO 0
`define LDSEL_TOP 5
`define UPDATE_BIT 0

// reset values
`define RST_CAL_CTRL 8'h00
`define RST_CNT_DLY 8'h00
`define RST_MON_LOCK 8'h00
`define RST_HOLDOVER 8'h00

// lock pin select codes
`define LOCK_SEL_FLAG 6'h00
`define LOCK_SEL_STAT_FLAG 6'h2d

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### hw/pll_regs_pkg.sv
package pll_regs_pkg;

   typedef enum logic [1:0]
   {
      SYNC_NONE = 2'h0,
      SYNC_ASYNC = 2'h1,
      SYNC_SYNC = 2'h2,
      SYNC_NONE2 = 2'h3
   } sync_mode_t;

   typedef struct packed
   {
      logic [7:0] cal_ctrl;
      logic [7:0] cnt_dly;
      logic [7:0] mon_lock;
      logic [7:0] holdover;
   } reg_set_t;

   typedef struct packed
   {
      logic digital_lock_flag;
      logic primary_ref_hi;
      logic primary_ref_lo;
      logic secondary_ref_hi;
      logic secondary_ref_lo;
      logic vco_freq_ok;
      logic sync_event;
   } pll_status_t;

endpackage

// ### hw/reg_shadow.sv
`include "pll_regs_defines.svh"

module reg_shadow
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // software side
   input wire logic wr_en,
   input wire logic [11:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic update,
   // copies
   output pll_regs_pkg::reg_set_t buf_set,
   output pll_regs_pkg::reg_set_t act_set
);

   pll_regs_pkg::reg_set_t buf_ff;
   pll_regs_pkg::reg_set_t nxt_buf;
   pll_regs_pkg::reg_set_t act_ff;
   pll_regs_pkg::reg_set_t nxt_act;

   assign buf_set = buf_ff;
   assign act_set = act_ff;

   always_comb
   begin
      nxt_buf = buf_ff;
      nxt_act = act_ff;
      if (wr_en)
      begin
         case (wr_addr)
            `IDX_CAL_CTRL: nxt_buf.cal_ctrl = wr_data;
            `IDX_CNT_DLY: nxt_buf.cnt_dly = wr_data;
            `IDX_MON_LOCK: nxt_buf.mon_lock = wr_data;
            `IDX_HOLDOVER: nxt_buf.holdover = wr_data;
            default: nxt_buf = buf_ff;
         endcase
      end
      if (update)
         nxt_act = nxt_buf;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         buf_ff <= {`RST_CAL_CTRL, `RST_CNT_DLY, `RST_MON_LOCK, `RST_HOLDOVER};
         act_ff <= {`RST_CAL_CTRL, `RST_CNT_DLY, `RST_MON_LOCK, `RST_HOLDOVER};
      end
      else if (ce)
      begin
         buf_ff <= nxt_buf;
         act_ff <= nxt_act;
      end
   end

endmodule // reg_shadow

// ### hw/lock_pin_mux.sv
`include "pll_regs_defines.svh"

module lock_pin_mux
(
   // select and sources
   input wire logic [5:0] sel,
   input wire logic digital_lock_flag,
   // pin level
   output logic pin_level
);

   always_comb
   begin
      pin_level = 1'b0;
      if (sel == `LOCK_SEL_FLAG)
         pin_level = digital_lock_flag;
      else if (!sel[`LDSEL_TOP])
         pin_level = 1'b0;
      else if (sel == `LOCK_SEL_STAT_FLAG)
         pin_level = digital_lock_flag;
      else
         pin_level = 1'b0;
   end

endmodule // lock_pin_mux

// ### hw/pll_control_register_slice.sv
// Contract
// - calibration starts on active bit rising
// - clearing active bit discards calibration result
// - two-bit field picks counter reset style
// - reference and feedback delays, reset zero
// - threshold bit picks high or low threshold
// - threshold leaves vco monitor alone
// - lock pin default shows lock flag
// - unassigned low codes drive ground
`include "pll_regs_defines.svh"

module pll_control_register_slice
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // axi4-lite write address
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // pll core status
   input pll_regs_pkg::pll_status_t status,
   // pll core controls
   output logic cal_start,
   output logic cal_discard,
   output logic cnt_reset_async,
   output logic cnt_reset_sync,
   output logic [2:0] ref_delay,
   output logic [2:0] fb_delay,
   output logic primary_ref_valid,
   output logic secondary_ref_valid,
   output logic vco_freq_valid,
   output logic lock_status_pin
);

   // ****************************************
   // address decode
   // ****************************************
   // word index from byte address
   function automatic logic [11:0] word_idx(input logic [11:0] a);
      word_idx = {2'h0, a[11:2]};
   endfunction

   function automatic logic mapped(input logic [11:0] i);
      mapped = (i == `IDX_CAL_CTRL) || (i == `IDX_CNT_DLY) || (i == `IDX_MON_LOCK) ||
               (i == `IDX_HOLDOVER) || (i == `IDX_UPDATE) || (i == `IDX_STATUS);
   endfunction

   // ****************************************
   // write channel
   // ****************************************
   logic awready_ff, nxt_awready;
   logic wready_ff, nxt_wready;
   logic [11:0] aw_idx_ff, nxt_aw_idx;
   logic [7:0] w_byte_ff, nxt_w_byte;
   logic w_lane_ff, nxt_w_lane;
   logic bvalid_ff, nxt_bvalid;
   logic [1:0] bresp_ff, nxt_bresp;
   logic wr_go;
   logic reg_wr;
   logic upd;

   assign wr_go = !awready_ff && !wready_ff && !bvalid_ff;
   assign reg_wr = wr_go && w_lane_ff && mapped(aw_idx_ff) && (aw_idx_ff != `IDX_UPDATE)
                   && (aw_idx_ff != `IDX_STATUS);
   // update command self-clears: writing one issues one transfer
   assign upd = wr_go && w_lane_ff && (aw_idx_ff == `IDX_UPDATE) && w_byte_ff[`UPDATE_BIT];

   always_comb
   begin
      nxt_awready = awready_ff;
      nxt_wready = wready_ff;
      nxt_aw_idx = aw_idx_ff;
      nxt_w_byte = w_byte_ff;
      nxt_w_lane = w_lane_ff;
      nxt_bvalid = bvalid_ff;
      nxt_bresp = bresp_ff;
      if (awvalid && awready_ff)
      begin
         nxt_awready = 1'b0;
         nxt_aw_idx = word_idx(awaddr);
      end
      if (wvalid && wready_ff)
      begin
         nxt_wready = 1'b0;
         nxt_w_byte = wdata[7:0];
         nxt_w_lane = wstrb[0];
      end
      if (wr_go)
      begin
         nxt_awready = 1'b1;
         nxt_wready = 1'b1;
         nxt_bvalid = 1'b1;
         nxt_bresp = mapped(aw_idx_ff) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_ff && bready)
         nxt_bvalid = 1'b0;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         awready_ff <= 1'b1;
         wready_ff <= 1'b1;
         aw_idx_ff <= 12'h000;
         w_byte_ff <= 8'h00;
         w_lane_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= `RESP_OKAY;
      end
      else if (ce)
      begin
         awready_ff <= nxt_awready;
         wready_ff <= nxt_wready;
         aw_idx_ff <= nxt_aw_idx;
         w_byte_ff <= nxt_w_byte;
         w_lane_ff <= nxt_w_lane;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
      end
   end

   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;

   // ****************************************
   // register copies
   // ****************************************
   pll_regs_pkg::reg_set_t buf_set;
   pll_regs_pkg::reg_set_t act_set;

   reg_shadow u_shadow
   (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .wr_en(reg_wr),
      .wr_addr(aw_idx_ff),
      .wr_data(w_byte_ff),
      .update(upd),
      .buf_set(buf_set),
      .act_set(act_set)
   );

   // ****************************************
   // read channel
   // ****************************************

   logic rvalid_ff, nxt_rvalid;
   logic arready_ff, nxt_arready;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0] rresp_ff, nxt_rresp;
   logic [11:0] ridx;
   logic cal_prev_ff, nxt_cal_prev;
   logic cal_active_ff, nxt_cal_active;
   logic cal_start_ff, nxt_cal_start;
   logic cal_discard_ff, nxt_cal_discard;
   logic arst_ff, nxt_arst;
   logic srst_ff, nxt_srst;
   logic [2:0] rdly_ff, nxt_rdly;
   logic [2:0] ndly_ff, nxt_ndly;
   logic primary_ref_valid_ff, nxt_primary;
   logic secondary_ref_valid_ff, nxt_secondary;
   logic vco_freq_valid_ff, nxt_vco;
   logic lock_pin_ff, nxt_lock_pin;
   logic mux_level;
   logic cal_bit;
   pll_regs_pkg::sync_mode_t smode;

   assign ridx = word_idx(araddr);
   always_comb
   begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (arvalid && !rvalid_ff)
      begin
         nxt_rvalid = 1'b1;
         nxt_rresp = mapped(ridx) ? `RESP_OKAY : `RESP_SLVERR;
         case (ridx)
            `IDX_CAL_CTRL: nxt_rdata = {24'h000000, buf_set.cal_ctrl};
            `IDX_CNT_DLY: nxt_rdata = {24'h000000, buf_set.cnt_dly};
            `IDX_MON_LOCK: nxt_rdata = {24'h000000, buf_set.mon_lock};
            `IDX_HOLDOVER: nxt_rdata = {24'h000000, buf_set.holdover};
            `IDX_STATUS: nxt_rdata = {24'h000000, cal_active_ff, status.digital_lock_flag,
                                      vco_freq_valid_ff, secondary_ref_valid_ff,
                                      primary_ref_valid_ff, lock_pin_ff, 2'h0};
            default: nxt_rdata = 32'h00000000;
         endcase
      end
      else if (rvalid_ff && rready)
         nxt_rvalid = 1'b0;
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
         rdata_ff <= 32'h00000000;
         rresp_ff <= `RESP_OKAY;
      end
      else if (ce)
      begin
         rvalid_ff <= nxt_rvalid;
         arready_ff <= nxt_arready;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;

   // ****************************************
   // pll control outputs
   // ****************************************
   assign cal_bit = act_set.cal_ctrl[`CAL_NOW_BIT];
   assign smode = pll_regs_pkg::sync_mode_t'(act_set.cnt_dly[`SYNC_MODE_HI:`SYNC_MODE_LO]);

   lock_pin_mux u_lock_mux
   (
      .sel(act_set.mon_lock[`LDSEL_HI:`LDSEL_LO]),
      .digital_lock_flag(status.digital_lock_flag),
      .pin_level(mux_level)
   );

   always_comb
   begin
      nxt_cal_prev = cal_bit;
      // start only on zero to one
      nxt_cal_start = cal_bit && !cal_prev_ff;
      nxt_cal_discard = !cal_bit && cal_prev_ff;
      nxt_cal_active = cal_bit;
      nxt_arst = 1'b0;
      nxt_srst = 1'b0;
      case (smode)
         pll_regs_pkg::SYNC_ASYNC: nxt_arst = status.sync_event;
         pll_regs_pkg::SYNC_SYNC: nxt_srst = status.sync_event;
         default: nxt_arst = 1'b0;
      endcase
      nxt_rdly = act_set.cnt_dly[`RDLY_HI:`RDLY_LO];
      nxt_ndly = act_set.cnt_dly[`NDLY_HI:`NDLY_LO];
      if (act_set.mon_lock[`THR_BIT])
      begin
         nxt_primary = status.primary_ref_lo;
         nxt_secondary = status.secondary_ref_lo;
      end
      else
      begin
         nxt_primary = status.primary_ref_hi;
         nxt_secondary = status.secondary_ref_hi;
      end
      nxt_vco = status.vco_freq_ok;
      nxt_lock_pin = mux_level;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cal_prev_ff <= 1'b0;
         cal_active_ff <= 1'b0;
         cal_start_ff <= 1'b0;
         cal_discard_ff <= 1'b0;
         arst_ff <= 1'b0;
         srst_ff <= 1'b0;
         rdly_ff <= 3'h0;
         ndly_ff <= 3'h0;
         primary_ref_valid_ff <= 1'b0;
         secondary_ref_valid_ff <= 1'b0;
         vco_freq_valid_ff <= 1'b0;
         lock_pin_ff <= 1'b0;
      end
      else if (ce)
      begin
         cal_prev_ff <= nxt_cal_prev;
         cal_active_ff <= nxt_cal_active;
         cal_start_ff <= nxt_cal_start;
         cal_discard_ff <= nxt_cal_discard;
         arst_ff <= nxt_arst;
         srst_ff <= nxt_srst;
         rdly_ff <= nxt_rdly;
         ndly_ff <= nxt_ndly;
         primary_ref_valid_ff <= nxt_primary;
         secondary_ref_valid_ff <= nxt_secondary;
         vco_freq_valid_ff <= nxt_vco;
         lock_pin_ff <= nxt_lock_pin;
      end
   end

   assign cal_start = cal_start_ff;
   assign cal_discard = cal_discard_ff;
   assign cnt_reset_async = arst_ff;
   assign cnt_reset_sync = srst_ff;
   assign ref_delay = rdly_ff;
   assign fb_delay = ndly_ff;
   assign primary_ref_valid = primary_ref_valid_ff;
   assign secondary_ref_valid = secondary_ref_valid_ff;
   assign vco_freq_valid = vco_freq_valid_ff;
   assign lock_status_pin = lock_pin_ff;

endmodule // pll_control_register_slice

// ### tb/pll_control_register_slice_chk.sv
module pll_control_register_slice_chk
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   // core side
   input pll_regs_pkg::pll_status_t status,
   input wire logic cal_start,
   input wire logic cal_discard,
   input wire logic cnt_reset_async,
   input wire logic cnt_reset_sync,
   input wire logic [2:0] ref_delay,
   input wire logic [2:0] fb_delay,
   input wire logic primary_ref_valid,
   input wire logic vco_freq_valid,
   input wire logic lock_status_pin
);
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence wr_taken_s;
      awvalid && awready && wvalid && wready && ce;
   endsequence
   sequence rd_taken_s;
      arvalid && arready && ce;
   endsequence

   wr_answer_a: assert property (wr_taken_s |-> ##[1:3] bvalid)
      else $error("write answer late");
   rd_answer_a: assert property (rd_taken_s |-> ##[1:2] rvalid)
      else $error("read answer late");
   bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped");
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped");
   // a steady one must not retrigger
   cal_pulse_a: assert property (cal_start |=> !cal_start && !cal_discard)
      else $error("calibrate start not a pulse");
   discard_pulse_a: assert property (cal_discard |=> !cal_discard && !cal_start)
      else $error("discard not a pulse");
   sync_mode_a: assert property ($past(ce) && (cnt_reset_async || cnt_reset_sync) |->
      $past(status.sync_event) && !(cnt_reset_async && cnt_reset_sync))
      else $error("counter reset without cause");
   ref_thresh_a: assert property ($past(rst_b) && $past(ce) && primary_ref_valid |->
      $past(status.primary_ref_hi || status.primary_ref_lo))
      else $error("reference valid without cause");
   vco_follow_a: assert property ($past(rst_b) && $past(ce) |->
      vco_freq_valid == $past(status.vco_freq_ok))
      else $error("vco valid wrong");
   lock_pin_a: assert property ($past(rst_b) && $past(ce) && lock_status_pin |->
      $past(status.digital_lock_flag))
      else $error("lock pin high while unlocked");
   // active fields move only as an update write is answered
   delay_upd_a: assert property ($changed({ref_delay, fb_delay}) |-> $past(bvalid))
      else $error("delay changed without update");
endmodule // pll_control_register_slice_chk

bind pll_control_register_slice pll_control_register_slice_chk chk_i (.*);

// ### tb/pll_control_register_slice_tb.sv
module pll_control_register_slice_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // signals and tasks
   // ****************
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic ce = 1'h1;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   pll_regs_pkg::pll_status_t status = 7'h00;
   logic cal_start, cal_discard, cnt_reset_async, cnt_reset_sync;
   logic primary_ref_valid, secondary_ref_valid, vco_freq_valid, lock_status_pin;
   logic [2:0] ref_delay, fb_delay;
   logic [11:0] adr [4] = '{12'h060, 12'h064, 12'h068, 12'h074};
   logic [5:0] code [5] = '{6'h00, 6'h05, 6'h1f, 6'h2d, 6'h20};
   int bad_count = 0;
   int total_checks = 0;
   int starts = 0;
   int drops = 0;

   pll_control_register_slice DUT (.*);

   always #20 clk = ~clk;

   always @(posedge clk)
   begin
      if (cal_start === 1'h1)
         starts++;
      if (cal_discard === 1'h1)
         drops++;
   end

   task results;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
      end
      while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk(bresp, er);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'h0;
      end
      while (rvalid !== 1'h1);
      rready <= 1'h0;
      chk(rdata, exp);
      chk(rresp, er);
   endtask

   // the active copy reaches the outputs one edge after the update lands
   task upd;
      wr(12'h8c8, 8'h01, 2'h0);
      repeat (2) @(posedge clk);
   endtask

   task st(input logic [6:0] s);
      @(posedge clk);
      status <= s;
      repeat (2) @(posedge clk);
   endtask

   // ****************
   // tests
   // ****************
   initial
   begin
      repeat (6) @(posedge clk);
      rst_b <= 1'h1;
      for (int i = 0; i < 4; i++)
         rd(adr[i], 32'h0, 2'h0);
      chk({ref_delay, fb_delay}, 6'h00);
      wr(12'h064, 8'h6b, 2'h0);
      rd(12'h064, 32'h6b, 2'h0);
      repeat (2) @(posedge clk);
      chk({ref_delay, fb_delay}, 6'h00);
      upd;
      chk({ref_delay, fb_delay}, {3'h5, 3'h3});
      for (int m = 0; m < 4; m++)
      begin
         wr(12'h064, {m[1:0], 6'h00}, 2'h0);
         upd;
         st(7'h01);
         chk({cnt_reset_async, cnt_reset_sync}, {m == 1, m == 2});
         st(7'h00);
      end
      for (int t = 0; t < 2; t++)
      begin
         wr(12'h068, {1'h0, t[0], 6'h00}, 2'h0);
         upd;
         // only the low thresholds and the vco flag are passed here
         st(7'h16);
         chk({primary_ref_valid, secondary_ref_valid, vco_freq_valid}, {t[0], t[0], 1'h1});
         st(7'h3c);
         chk({primary_ref_valid, secondary_ref_valid, vco_freq_valid}, 3'h6);
      end
      // clock enable low must freeze the vco valid output flop
      ce <= 1'h0;
      st(7'h02);
      chk(vco_freq_valid, 1'h0);
      ce <= 1'h1;
      st(7'h02);
      chk(vco_freq_valid, 1'h1);
      for (int i = 0; i < 5; i++)
      begin
         wr(12'h068, {2'h1, code[i]}, 2'h0);
         upd;
         st(7'h40);
         chk(lock_status_pin, code[i] == 6'h00 || code[i] == 6'h2d);
         st(7'h00);
         chk(lock_status_pin, 1'h0);
      end
      st(7'h3c);
      wr(12'h074, 8'h00, 2'h0);
      wr(12'h060, 8'h00, 2'h0);
      upd;
      wr(12'h060, 8'h01, 2'h0);
      repeat (4) @(posedge clk);
      chk(starts, 32'h0);
      upd;
      chk(starts, 32'h1);
      upd;
      chk(starts, 32'h1);
      chk(drops, 32'h0);
      rd(12'h8cc, 32'h98, 2'h0);
      wr(12'h060, 8'h00, 2'h0);
      upd;
      chk(drops, 32'h1);
      wr(12'h100, 8'h5a, 2'h2);
      rd(12'h100, 32'h0, 2'h2);
      rd(12'h8c8, 32'h0, 2'h0);
      results;
   end

   // a hung handshake ends the run here
   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      results;
   end
endmodule // pll_control_register_slice_tb
